// [core/cpsc_config_pins.sv]
// Purpose: Configuration handshake and shared pin steering of the device
// Assumes: Slave SPI clock pin enters as its own clock; pins are raw levels
// Notes:   Pad outputs are registered; pull-downs are reported, not modelled

// Notes on behaviour
// R1: Debug select high gives the four shared pins to boundary scan.
// R2: In user mode the bitstream drive picks each user pin function.
// R3: A low configuration request starts configuration.
// R4: Initialization pin is driven low while initializing.
// R5: Initialization pin released after initialization; download only afterwards.
// R6: Download waits while someone holds the initialization pin low.
// R7: Completion pin driven low through configuration, released on completion.
// R8: No wake into user mode while completion pin is held low.
// R9: During configuration user pins float with weak pull-down.
// R10: Unused user pins float with pull-down after configuration.
// R11: Slave SPI or I2C mode detected in activation; pins assigned by mode.
// R12: Shared pins unused by the detected mode float during configuration.
// R13: After configuration shared pins become user or alternate functions.
// R14: Slave SPI uses the scan pins as data out, in, select, clock.
// R15: Master SPI drives clock, select, data out, samples data in; quad widens.
// R16: I2C mode uses the serial data and clock pins.
// R17: External handshake levels are synchronised before use.
module cpsc_config_pins
  import cpsc_pkg::*;
#(
  parameter int NUM_USER = 8,
  parameter logic [DIV_W-1:0] MCLK_DIV = DIV_DEF
) (
  // Clocks and reset
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       clk_en,
  input  wire logic                       link_clk,
  // Pad input levels
  input  wire logic [SH_N-1:0]            shared_pin_i,
  input  wire logic                       jtag_sel,
  // Core side controls
  input  wire logic                       quad_sel,
  input  wire logic                       load_done,
  input  cpsc_drv_t                       tap_tdo,
  input  cpsc_drv_t [SH_N-1:0]            shared_drv,
  input  wire logic [SH_N-1:0]            shared_used,
  input  cpsc_drv_t [NUM_USER-1:0]        user_drv,
  input  wire logic [NUM_USER-1:0]        user_used,
  // Pad drives
  output cpsc_pad_t [SH_N-1:0]            shared_pad_q,
  output cpsc_pad_t [NUM_USER-1:0]        user_pad_q,
  // Configuration data and status
  output logic [BYTE_W-1:0]               cfg_byte_q,
  output logic                            cfg_byte_vld_q,
  output cpsc_mode_t                      cfg_mode_q,
  output logic                            user_mode_q
);

  logic [SYNC_N-1:0] raw;
  logic [SYNC_N-1:0] s1_q;
  logic [SYNC_N-1:0] s2_q;
  logic [SYNC_N-1:0] s3_q;
  logic [SYNC_N-1:0] flt_q;
  logic [SYNC_N-1:0] agree;
  logic              tog_seen_q;
  logic              byte_evt;
  logic              req_low;
  cpsc_state_t       st_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [BIT_W-1:0]  lcnt_q;
  logic [BYTE_W-1:0] lsh_q;
  logic [BYTE_W-1:0] lbyte_q;
  logic              ltog_q;
  logic              lcs;
  logic [DIV_W-1:0]  div_q;
  logic              mclk_q;
  logic [BYTE_W-1:0] msh_q;
  logic [BIT_W-1:0]  mcnt_q;
  logic [BIT_W-1:0]  mcnt_d;
  logic              mfin_q;
  logic              m_run;
  logic              quad;
  cpsc_pad_t [SH_N-1:0]     sp_d;
  cpsc_pad_t [NUM_USER-1:0] up_d;
  logic              user_hiz;

  // Link side: slave SPI shifter on the configuration host's clock
  assign lcs = shared_pin_i[P_TMS];

  // Chip select high ends a frame even with the clock stopped
  always_ff @(posedge link_clk or negedge rst_b or posedge lcs) begin
    if (!rst_b) begin
      lcnt_q <= '0;
    end else if (lcs) begin
      lcnt_q <= '0;
    end else begin
      lcnt_q <= lcnt_q + STEP_1; // R14
    end
  end

  // Shift data input; hand each full byte over by toggle
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lsh_q   <= '0;
      lbyte_q <= '0;
      ltog_q  <= 1'h0;
    end else if (!lcs) begin
      lsh_q <= {lsh_q[BYTE_W-2:0], shared_pin_i[P_TDI]}; // R14
      if (lcnt_q == BIT_LAST) begin
        lbyte_q <= {lsh_q[BYTE_W-2:0], shared_pin_i[P_TDI]};
        ltog_q  <= ~ltog_q;
      end
    end
  end

  // Pin and cross-domain inputs: three stages, accept when stages two and three agree
  assign raw = {ltog_q, jtag_sel, shared_pin_i[P_MS_OUT], shared_pin_i[P_QD3], shared_pin_i[P_QD2],
                shared_pin_i[P_MS_IN], shared_pin_i[P_SCL], shared_pin_i[P_TMS],
                shared_pin_i[P_DONE], shared_pin_i[P_INIT], shared_pin_i[P_REQ]};
  assign agree = s2_q ~^ s3_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q  <= SYNC_RST;
      s2_q  <= SYNC_RST;
      s3_q  <= SYNC_RST;
      flt_q <= SYNC_RST;
    end else if (clk_en) begin
      s1_q  <= raw; // R17
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= (flt_q & ~agree) | (s3_q & agree); // R17
    end
  end

  // Byte event from the link toggle; byte word is stable by then
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tog_seen_q <= 1'h0;
    end else if (clk_en) begin
      tog_seen_q <= flt_q[S_TOG];
    end
  end
  assign byte_evt = flt_q[S_TOG] ^ tog_seen_q;
  assign req_low  = !flt_q[S_REQ];

  // Configuration sequence; reset itself starts one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= ST_INIT;
      cnt_q <= '0;
    end else if (clk_en) begin
      if (req_low) begin
        st_q  <= ST_INIT; // R3
        cnt_q <= '0;
      end else begin
        case (st_q)
          ST_INIT: begin
            if (cnt_q == CNT_W'(INIT_CYC - 1)) begin
              st_q  <= ST_REL; // R5
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + CNT_W'(1);
            end
          end
          ST_REL: begin
            if (flt_q[S_INIT]) begin
              st_q <= ST_DET; // R6
            end
          end
          ST_DET: begin
            if ((!flt_q[S_SCS] && !flt_q[S_JTAG]) || !flt_q[S_SCL]
                || cnt_q == CNT_W'(DET_CYC - 1)) begin
              st_q  <= ST_LOAD; // R11
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + CNT_W'(1);
            end
          end
          ST_LOAD: begin
            if (load_done) begin
              st_q <= ST_WAKE;
            end
          end
          ST_WAKE: begin
            if (flt_q[S_DONE]) begin
              st_q <= ST_USER; // R8
            end
          end
          ST_USER: begin
            st_q <= ST_USER;
          end
          default: begin
            st_q <= ST_INIT;
          end
        endcase
      end
    end
  end

  // Mode detection during slave activation; silence means master
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_mode_q <= MD_NONE;
    end else if (clk_en) begin
      if (req_low || st_q == ST_INIT) begin
        cfg_mode_q <= MD_NONE;
      end else if (st_q == ST_DET && !req_low) begin
        if (!flt_q[S_SCS] && !flt_q[S_JTAG]) begin
          cfg_mode_q <= MD_SSPI; // R11
        end else if (!flt_q[S_SCL]) begin
          cfg_mode_q <= MD_I2C; // R16
        end else if (cnt_q == CNT_W'(DET_CYC - 1)) begin
          cfg_mode_q <= quad_sel ? MD_QSPI : MD_MSPI;
        end
      end
    end
  end

  // Master SPI reader: divided clock, sample on rising edge
  assign quad   = (cfg_mode_q == MD_QSPI);
  assign m_run  = (st_q == ST_LOAD) && (quad || cfg_mode_q == MD_MSPI);
  assign mcnt_d = mcnt_q + (quad ? STEP_4 : STEP_1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q  <= '0;
      mclk_q <= 1'h0;
      msh_q  <= '0;
      mcnt_q <= '0;
      mfin_q <= 1'h0;
    end else if (clk_en) begin
      mfin_q <= 1'h0;
      if (!m_run) begin
        div_q  <= '0;
        mclk_q <= 1'h0;
        mcnt_q <= '0;
      end else if (div_q == MCLK_DIV - DIV_W'(1)) begin
        div_q  <= '0;
        mclk_q <= ~mclk_q; // R15
        if (!mclk_q) begin
          // Sync delay limits the usable master clock rate
          msh_q  <= quad ? {msh_q[3:0], flt_q[S_QD3], flt_q[S_QD2], flt_q[S_MS_IN], flt_q[S_MS_OUT]}
                         : {msh_q[BYTE_W-2:0], flt_q[S_MS_IN]}; // R15
          mcnt_q <= mcnt_d;
          mfin_q <= (mcnt_d == '0);
        end
      end else begin
        div_q <= div_q + DIV_W'(1);
      end
    end
  end

  // Configuration byte out, from either source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_byte_q     <= '0;
      cfg_byte_vld_q <= 1'h0;
    end else if (clk_en) begin
      cfg_byte_vld_q <= 1'h0;
      if (st_q == ST_LOAD && cfg_mode_q == MD_SSPI && byte_evt) begin
        cfg_byte_q     <= lbyte_q; // R14
        cfg_byte_vld_q <= 1'h1;
      end else if (mfin_q) begin
        cfg_byte_q     <= msh_q;
        cfg_byte_vld_q <= 1'h1;
      end
    end
  end

  // Pad steering; everything floats with pull-down unless claimed
  always_comb begin
    for (int i = 0; i < SH_N; i++) begin
      sp_d[i] = PAD_HIZ; // R12
      if (st_q == ST_USER && shared_used[i]) begin
        sp_d[i] = '{o: shared_drv[i].o, oe: shared_drv[i].oe, pd: 1'h0}; // R13
      end
    end
    for (int j = 0; j < NUM_USER; j++) begin
      up_d[j] = PAD_HIZ; // R9 R10
      if (st_q == ST_USER && user_used[j]) begin
        up_d[j] = '{o: user_drv[j].o, oe: user_drv[j].oe, pd: 1'h0}; // R2
      end
    end
    if (st_q != ST_USER) begin
      sp_d[P_REQ]  = PAD_IN;
      sp_d[P_INIT] = (st_q == ST_INIT) ? PAD_LOW : PAD_IN; // R4 R5
      sp_d[P_DONE] = (st_q == ST_WAKE) ? PAD_IN : PAD_LOW; // R7
      if (m_run) begin
        sp_d[P_MCLK]  = '{o: mclk_q, oe: 1'h1, pd: 1'h0}; // R15
        sp_d[P_MCS]     = PAD_LOW;
        sp_d[P_MCS_ALT] = PAD_LOW;
        sp_d[P_MS_OUT]  = quad ? PAD_IN : PAD_LOW;
        sp_d[P_MS_IN]   = PAD_IN;
        if (quad) begin
          sp_d[P_QD2] = PAD_IN; // R15
          sp_d[P_QD3] = PAD_IN;
        end
      end
      if (cfg_mode_q == MD_SSPI) begin
        // Data out answers only while selected; no read-back data
        sp_d[P_TDO] = '{o: 1'h0, oe: !flt_q[S_SCS], pd: 1'h0}; // R14
        sp_d[P_TDI] = PAD_IN;
        sp_d[P_TMS] = PAD_IN;
        sp_d[P_TCK] = PAD_IN;
      end
      if (cfg_mode_q == MD_I2C) begin
        // Wired-AND lines; no protocol engine here
        sp_d[P_SDA] = PAD_IN; // R16
        sp_d[P_SCL] = PAD_IN;
      end
    end
    if (flt_q[S_JTAG]) begin
      sp_d[P_TDO] = '{o: tap_tdo.o, oe: tap_tdo.oe, pd: 1'h0}; // R1
      sp_d[P_TDI] = PAD_IN;
      sp_d[P_TMS] = PAD_IN;
      sp_d[P_TCK] = PAD_IN;
    end
  end

  // Pad and status registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shared_pad_q <= {SH_N{PAD_HIZ}};
      user_pad_q   <= {NUM_USER{PAD_HIZ}};
      user_mode_q  <= 1'h0;
    end else if (clk_en) begin
      shared_pad_q <= sp_d;
      user_pad_q   <= up_d;
      user_mode_q  <= (st_q == ST_USER);
    end
  end

  // Checks
  always_comb begin
    user_hiz = 1'h1;
    for (int k = 0; k < NUM_USER; k++) begin
      user_hiz = user_hiz & !user_pad_q[k].oe & user_pad_q[k].pd;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  req_start_a: assert property (clk_en && req_low |=> st_q == ST_INIT) // R3
    else $error("request did not restart configuration");
  init_drive_a: assert property (clk_en && st_q == ST_INIT |=> shared_pad_q[P_INIT] == PAD_LOW) // R4
    else $error("init pin not driven low");
  init_rel_a: assert property (st_q == ST_LOAD |-> !shared_pad_q[P_INIT].oe) // R5
    else $error("download while init pin driven");
  dl_hold_a: assert property (clk_en && !req_low && st_q == ST_REL && !flt_q[S_INIT] |=> st_q == ST_REL) // R6
    else $error("download started while init held");
  done_low_a: assert property (clk_en && st_q != ST_WAKE && st_q != ST_USER // R7
                               |=> shared_pad_q[P_DONE] == PAD_LOW)
    else $error("done pin not held low");
  wake_hold_a: assert property (clk_en && st_q == ST_WAKE && !flt_q[S_DONE] |=> st_q != ST_USER) // R8
    else $error("woke while done held low");
  cfg_float_a: assert property (clk_en && st_q != ST_USER |=> user_hiz) // R9
    else $error("user pin active during configuration");
  unused_pin_a: assert property (clk_en && st_q == ST_USER && !user_used[0] // R10
                                 |=> user_pad_q[0] == PAD_HIZ)
    else $error("unused user pin not floating");
  det_master_a: assert property (clk_en && !req_low && st_q == ST_DET && cnt_q == CNT_W'(DET_CYC - 1) // R11
                                 && flt_q[S_SCS] && flt_q[S_SCL]
                                 |=> cfg_mode_q == MD_MSPI || cfg_mode_q == MD_QSPI)
    else $error("master mode not chosen after timeout");
  sspi_quiet_a: assert property (clk_en && cfg_mode_q == MD_SSPI && st_q == ST_LOAD // R12
                                 |=> !shared_pad_q[P_MCLK].oe && !shared_pad_q[P_MCS].oe)
    else $error("master pins driven in slave mode");
  sspi_out_a: assert property (clk_en && cfg_mode_q == MD_SSPI && st_q != ST_USER && !flt_q[S_JTAG] // R14
                               && !flt_q[S_SCS] |=> shared_pad_q[P_TDO].oe)
    else $error("slave data out not enabled");
  // Any three registered clock levels in a running stretch hold an edge, for dividers up to two
  mclk_run_a: assert property ((clk_en && m_run) [*4] |-> MCLK_DIV > DIV_W'(2) // R15
                               || shared_pad_q[P_MCLK].o != $past(shared_pad_q[P_MCLK].o)
                               || $past(shared_pad_q[P_MCLK].o) != $past(shared_pad_q[P_MCLK].o, 2))
    else $error("master clock not toggling");
  jtag_route_a: assert property (clk_en && flt_q[S_JTAG] // R1
                                 |=> shared_pad_q[P_TDO].oe == $past(tap_tdo.oe) && !shared_pad_q[P_TCK].oe)
    else $error("scan port not routed");
  // Only bits whose second and third stages agreed may move
  sync_agree_a: assert property ($changed(flt_q) |-> $past(clk_en) // R17
                                 && ((flt_q ^ $past(flt_q)) & ($past(s2_q) ^ $past(s3_q))) == '0)
    else $error("filter changed without agreement");

  user_sspi_c: cover property (cfg_mode_q == MD_SSPI && st_q == ST_USER);
  master_byte_c: cover property (mfin_q && quad);
  link_byte_c: cover property (cfg_byte_vld_q && cfg_mode_q == MD_SSPI);
  scan_user_c: cover property (user_mode_q && flt_q[S_JTAG]);

endmodule

// [core/cpsc_pkg.sv]
// Purpose: Shared constants and types for configuration pin sharing control
// Assumes: 100 MHz system clock
// Notes:   Pin indices name the shared configuration pads
package cpsc_pkg;
  // Shared pad indices
  localparam int P_TDO   = 0;
  localparam int P_TDI   = 1;
  localparam int P_TMS   = 2;
  localparam int P_TCK   = 3;
  localparam int P_SDA   = 4;
  localparam int P_SCL   = 5;
  localparam int P_MCS_ALT = 6;
  localparam int P_QD3   = 7;
  localparam int P_QD2   = 8;
  localparam int P_MS_IN = 9;
  localparam int P_MS_OUT = 10;
  localparam int P_MCS   = 11;
  localparam int P_MCLK  = 12;
  localparam int P_REQ   = 13;
  localparam int P_INIT  = 14;
  localparam int P_DONE  = 15;
  localparam int SH_N    = 16;
  // Synchroniser slots
  localparam int S_REQ  = 0;
  localparam int S_INIT = 1;
  localparam int S_DONE = 2;
  localparam int S_SCS  = 3;
  localparam int S_SCL  = 4;
  localparam int S_MS_IN  = 5;
  localparam int S_QD2  = 6;
  localparam int S_QD3  = 7;
  localparam int S_MS_OUT = 8;
  localparam int S_JTAG = 9;
  localparam int S_TOG  = 10;
  localparam int SYNC_N = 11;
  localparam logic [SYNC_N-1:0] SYNC_RST = 11'h1FF;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int INIT_NS = 40000;
  localparam int INIT_CYC = (INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int DET_NS  = 1000;
  localparam int DET_CYC = (DET_NS * CLK_MHZ) / 1000;
  localparam int CNT_W   = 12;
  localparam int DIV_W   = 4;
  localparam logic [DIV_W-1:0] DIV_DEF = 4'h2;
  // Byte assembly
  localparam int BYTE_W = 8;
  localparam int BIT_W  = 3;
  localparam logic [BIT_W-1:0] STEP_1 = 3'h1;
  localparam logic [BIT_W-1:0] STEP_4 = 3'h4;
  localparam logic [BIT_W-1:0] BIT_LAST = 3'h7;

  typedef enum logic [2:0] {ST_INIT, ST_REL, ST_DET, ST_LOAD, ST_WAKE, ST_USER} cpsc_state_t;
  typedef enum logic [2:0] {MD_NONE, MD_MSPI, MD_QSPI, MD_SSPI, MD_I2C} cpsc_mode_t;

  typedef struct packed {
    logic o;
    logic oe;
    logic pd;
  } cpsc_pad_t;

  typedef struct packed {
    logic o;
    logic oe;
  } cpsc_drv_t;

  localparam cpsc_pad_t PAD_HIZ = '{o: 1'h0, oe: 1'h0, pd: 1'h1};
  localparam cpsc_pad_t PAD_IN  = '{o: 1'h0, oe: 1'h0, pd: 1'h0};
  localparam cpsc_pad_t PAD_LOW = '{o: 1'h0, oe: 1'h1, pd: 1'h0};
endpackage

// [verification/cpsc_host_model.sv]
// Purpose: Host model driving handshake and slave SPI pins
// Assumes: Open-drain pins read high while nobody pulls them low
// Notes:   Link clock stands still between frames; data released off-frame
module cpsc_host_model
  import cpsc_pkg::*;
(
  // Pin drive towards the device
  output logic [SH_N-1:0] ext_en,
  output logic [SH_N-1:0] ext_val,
  // Slave link clock
  output logic            link_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  assign link_clk = ext_val[P_TCK];

  // Idle: request high, select high, clock low, data released
  initial begin
    ext_en  = SH_N'((1 << P_REQ) | (1 << P_TMS) | (1 << P_TCK));
    ext_val = SH_N'((1 << P_REQ) | (1 << P_TMS));
  end

  // Request level, low asks for a configuration
  task automatic set_req(input logic lvl);
    ext_val[P_REQ] = lvl;
  endtask

  // Open-drain pull on init, done or serial clock pins
  task automatic hold_pin(input int idx, input logic on);
    ext_en[idx]  = on;
    ext_val[idx] = 1'b0;
  endtask

  // Select low also takes the data line
  task automatic select(input logic on);
    ext_val[P_TMS] = !on;
    ext_en[P_TDI]  = on;
  endtask

  // One byte, MSB first, data changed while the clock is low
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      ext_val[P_TDI] = b[i];
      #15 ext_val[P_TCK] = 1'b1;
      #15 ext_val[P_TCK] = 1'b0;
    end
    ext_val[P_TDI] = !b[0]; // No stale bit after the byte
  endtask
endmodule

// [verification/config_pin_sharing_control_tb.sv]
// Purpose: Self-checking bench for configuration pin sharing control
// Assumes: Used pads take {o,oe} with pull-down off
// Notes:   Master-mode bytes are not scored, only pad behaviour
module config_pin_sharing_control_tb
  import cpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NU = 8;
  localparam logic [SH_N-1:0] PULL_UP = 16'hE034; // Request, init, done, I2C pair, slave select

  logic                  clk;
  logic                  rst_b;
  logic                  clk_en;
  logic                  link_clk;
  logic [SH_N-1:0]       pin;
  logic                  jtag_sel;
  logic                  quad_sel;
  logic                  load_done;
  cpsc_drv_t             tap_tdo;
  cpsc_drv_t [SH_N-1:0]  shared_drv;
  logic [SH_N-1:0]       shared_used;
  cpsc_drv_t [NU-1:0]    user_drv;
  logic [NU-1:0]         user_used;
  cpsc_pad_t [SH_N-1:0]  pad;
  cpsc_pad_t [NU-1:0]    user_pad_q;
  logic [BYTE_W-1:0]     cfg_byte_q;
  logic                  cfg_byte_vld_q;
  cpsc_mode_t            cfg_mode_q;
  logic                  user_mode_q;
  logic [SH_N-1:0]       ext_en;
  logic [SH_N-1:0]       ext_val;
  logic [7:0]            exp_q[$];
  logic [7:0]            b;
  logic                  o0;
  logic                  mon_on;
  integer                seed;
  int                    n_errors;
  int                    checked;

  cpsc_config_pins #(.NUM_USER(NU), .MCLK_DIV(4'h2)) DUT (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .link_clk(link_clk),
    .shared_pin_i(pin), .jtag_sel(jtag_sel), .quad_sel(quad_sel),
    .load_done(load_done), .tap_tdo(tap_tdo), .shared_drv(shared_drv),
    .shared_used(shared_used), .user_drv(user_drv), .user_used(user_used),
    .shared_pad_q(pad), .user_pad_q(user_pad_q), .cfg_byte_q(cfg_byte_q),
    .cfg_byte_vld_q(cfg_byte_vld_q), .cfg_mode_q(cfg_mode_q), .user_mode_q(user_mode_q));

  cpsc_host_model host (.ext_en(ext_en), .ext_val(ext_val), .link_clk(link_clk));

  // Wired level: any low driver wins; board pull-ups beat the weak pull-down
  always_comb begin
    for (int i = 0; i < SH_N; i++) begin
      if ((pad[i].oe && !pad[i].o) || (ext_en[i] && !ext_val[i])) pin[i] = 1'b0;
      else if (pad[i].oe || ext_en[i] || PULL_UP[i]) pin[i] = 1'b1;
      else pin[i] = !pad[i].pd;
    end
  end

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Inputs move a fixed 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Each byte pulse takes the oldest expected byte, looked at mid-cycle once settled
  always @(negedge clk) begin
    if (mon_on && cfg_byte_vld_q === 1'b1)
      check(32'(cfg_byte_q), exp_q.size() ? 32'(exp_q.pop_front()) : 32'hFFFF);
  end

  // Hang guard, over twice the run of the four configuration passes
  initial begin
    #400000;
    n_errors++;
    stop_test();
  end

  initial begin
    seed        = 32'h00d8978a;
    rst_b       = 1'b0;
    clk_en      = 1'b1;
    jtag_sel    = 1'b0;
    quad_sel    = 1'b0;
    load_done   = 1'b0;
    mon_on      = 1'b1;
    tap_tdo     = 2'($random(seed));
    shared_drv  = 32'($random(seed));
    shared_used = 16'($random(seed)) & ~(16'h1 << P_REQ); // A user drive on the request pad would restart
    user_drv    = 16'($random(seed));
    user_used   = 8'($random(seed));
    step(2);
    check(32'(user_pad_q), 32'({NU{PAD_HIZ}}));
    step(2);
    rst_b = 1'b1;
    host.hold_pin(P_INIT, 1'b1);
    host.select(1'b1);
    step(3);
    check(32'(pad[P_INIT]), 32'(PAD_LOW));
    check(32'(pad[P_DONE]), 32'(PAD_LOW));
    step(INIT_CYC + 100);
    check(32'(pad[P_INIT]), 32'(PAD_IN));
    check(32'(cfg_mode_q), 32'(MD_NONE));
    host.hold_pin(P_INIT, 1'b0);
    for (int i = 0; i < 60 && cfg_mode_q !== MD_SSPI; i++) step(1);
    step(1); // Pads follow the mode one edge later
    check(32'(cfg_mode_q), 32'(MD_SSPI));
    check(32'(pad[P_TDO].oe), 32'h1);
    check(32'(pad[P_MCLK]), 32'(PAD_HIZ));
    check(32'(user_pad_q), 32'({NU{PAD_HIZ}}));
    repeat (4) begin
      b = 8'($random(seed));
      exp_q.push_back(b);
      host.send_byte(b);
    end
    step(20);
    host.select(1'b0);
    check(32'(exp_q.size()), 32'h0);
    host.hold_pin(P_DONE, 1'b1);
    load_done = 1'b1;
    step(30);
    check(32'(pad[P_DONE]), 32'(PAD_IN));
    check(32'(user_mode_q), 32'h0);
    host.hold_pin(P_DONE, 1'b0);
    step(12);
    check(32'(user_mode_q), 32'h1);
    for (int i = 0; i < NU; i++)
      check(32'(user_pad_q[i]), user_used[i] ? {29'h0, user_drv[i], 1'b0} : 32'(PAD_HIZ));
    check(32'(pad[P_SDA]), shared_used[P_SDA] ? {29'h0, shared_drv[P_SDA], 1'b0} : 32'(PAD_HIZ));
    jtag_sel = 1'b1;
    step(8);
    check(32'(pad[P_TDO]), {29'h0, tap_tdo, 1'b0});
    check(32'(pad[P_TDI].oe), 32'h0);
    jtag_sel = 1'b0;
    // Reconfigure into I2C, single master and quad master
    for (int k = 0; k < 3; k++) begin
      load_done = 1'b0;
      quad_sel  = (k == 2);
      mon_on    = (k == 0);
      host.set_req(1'b0);
      step(8);
      check(32'(pad[P_INIT]), 32'(PAD_LOW));
      check(32'(user_mode_q), 32'h0);
      check(32'(user_pad_q), 32'({NU{PAD_HIZ}}));
      host.set_req(1'b1);
      host.hold_pin(P_SCL, k == 0);
      step(INIT_CYC + 20);
      check(32'(pad[P_INIT]), 32'(PAD_IN));
      step(DET_CYC + 30);
      check(32'(cfg_mode_q), 32'(k == 0 ? MD_I2C : k == 1 ? MD_MSPI : MD_QSPI));
      if (k == 0) begin
        check(32'(pad[P_SDA].oe), 32'h0);
        check(32'(pad[P_MCLK]), 32'(PAD_HIZ));
      end else begin
        check(32'(pad[P_MCS]), 32'(PAD_LOW));
        o0 = pad[P_MCLK].o;
        step(2);
        check(32'(pad[P_MCLK].o), 32'(!o0));
        check(32'(pad[P_MCLK].oe), 32'h1);
        // Enable low must freeze the master clock
        clk_en = 1'b0;
        o0     = pad[P_MCLK].o;
        step(5);
        check(32'(pad[P_MCLK].o), 32'(o0));
        clk_en = 1'b1;
      end
      if (k == 1) check(32'(pad[P_MS_OUT]), 32'(PAD_LOW));
      host.hold_pin(P_SCL, 1'b0);
    end
    stop_test();
  end
endmodule
